// >>> byte_fifo.sv
// Small FIFO with a registered output stage.
`timescale 1ns/1ps
module byte_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 4
) (
  // Clock, reset and clock enable.
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Filling and draining sides.
  byte_stream_if.snk wr,
  byte_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("FIFO depth must be a power of two of at least two.");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;

  wire push = ce && wr.valid && wr.ready;
  wire load = ce && (cnt_q != '0) && (!rd.valid || rd.ready);
  wire [AW:0] push_w = {{AW{1'b0}}, push};
  wire [AW:0] load_w = {{AW{1'b0}}, load};

  assign wr.ready = (cnt_q != (AW + 1)'(DEPTH));

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      rd.valid <= 1'b0;
      rd.data <= '0;
    end else if (ce) begin
      cnt_q <= cnt_q + push_w - load_w;
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (load) begin
        rp_q <= rp_q + 1'b1;
        rd.data <= mem[rp_q];
        rd.valid <= 1'b1;
      end else if (rd.ready) begin
        rd.valid <= 1'b0;
      end
    end
  end
endmodule

// >>> byte_stream_if.sv
// Valid/ready stream carrying one frame byte and its last flag.
`timescale 1ns/1ps
interface byte_stream_if #(parameter int W = 9);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface

// >>> ecpri_frame_builder.sv
// Test frame builder: headers, payload sequence and correction bytes.
// Summary of operation
// - Append correction bytes only when enabled at high rate.
// - High rate fixes 25G and one interface.
// - Low rate allows 10 Mbit/s to 10 Gbit/s.
// - Opposite rate frozen while that port runs.
// - At most two VLAN tags.
// - Revision 0001b, reserved bits 000b, fixed.
// - Concatenation flag marks a following message.
// - Length counts message header plus payload.
// - Data and control messages carry series, sequence.
// - Memory access id and read/write code.
// - Request/response code 0, 1, 2 only.
// - Element, address and two-byte length present.
// - Delay message carries one-byte measurement id.
// - Delay message carries action and timestamp.
// - Compensation only for actions 00, 02, 05.
// - Reset id and operation code 1 or 2.
// - Element id selects one function instance.
`timescale 1ns/1ps
module ecpri_frame_builder #(
  parameter int FIFO_DEPTH = 4
) (
  // Clock, reset and clock enable.
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata_q,
  // Opposite port state.
  input wire logic opp_port_active,
  // Frame byte stream.
  output logic [7:0] out_data,
  output logic out_last,
  output logic out_valid,
  input wire logic out_ready,
  // Port settings in force.
  output logic [15:0] port_rate_q,
  output logic [1:0] iface_q,
  output logic fec_active_q,
  output logic opp_hi_rate_q
);
  ecpri_pkg::phase_e phase_q;
  ecpri_pkg::phase_e ph_next;
  logic run_q;
  logic fec_en_q;
  logic hi_rate_q;
  logic concat_q;
  logic [1:0] vlan_depth_q;
  logic [7:0] msg_q;
  logic [31:0] ids_q;
  logic [31:0] rma_q;
  logic [31:0] mem_addr_q;
  logic [15:0] rma_len_q;
  logic [15:0] dly_q;
  logic [31:0] ts_q;
  logic [31:0] comp_q;
  logic [23:0] rst_q;
  logic [15:0] paylen_q;
  logic [11:0] vid_q;
  logic reject_q;
  logic [15:0] frames_q;
  logic [15:0] cnt_q;
  logic [7:0] par_q;
  logic [7:0] sum_q;
  logic [30:0] prbs_q;
  logic [ecpri_pkg::MH_W-1:0] mh_vec;
  logic [15:0] mh_len;
  logic [7:0] gen_byte;

  byte_stream_if #(.W(9)) gen_s();
  byte_stream_if #(.W(9)) out_s();

  byte_fifo #(.W(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .wr(gen_s),
    .rd(out_s)
  );

  assign out_data = out_s.data[7:0];
  assign out_last = out_s.data[8];
  assign out_valid = out_s.valid;
  assign out_s.ready = out_ready;

  // Register decode.
  wire wr_ctrl = wr_en && (addr == ecpri_pkg::A_CTRL);
  wire wr_msg = wr_en && (addr == ecpri_pkg::A_MSG);
  wire wr_ids = wr_en && (addr == ecpri_pkg::A_IDS);
  wire wr_rma = wr_en && (addr == ecpri_pkg::A_RMA);
  wire wr_madr = wr_en && (addr == ecpri_pkg::A_MADR);
  wire wr_mlen = wr_en && (addr == ecpri_pkg::A_MLEN);
  wire wr_dly = wr_en && (addr == ecpri_pkg::A_DLY);
  wire wr_ts = wr_en && (addr == ecpri_pkg::A_TS);
  wire wr_comp = wr_en && (addr == ecpri_pkg::A_COMP);
  wire wr_rst = wr_en && (addr == ecpri_pkg::A_RST);
  wire wr_plen = wr_en && (addr == ecpri_pkg::A_PLEN);
  wire wr_rate = wr_en && (addr == ecpri_pkg::A_RATE);
  wire wr_vid = wr_en && (addr == ecpri_pkg::A_VID);
  wire wr_stat = wr_en && (addr == ecpri_pkg::A_STAT);
  wire wr_opp = wr_en && (addr == ecpri_pkg::A_OPP);

  // Write checks; a refused write leaves the register unchanged.
  wire [1:0] w_vlan = wdata[ecpri_pkg::C_VL +: 2];
  wire [1:0] vlan_clamp = (w_vlan > ecpri_pkg::VLAN_MAX) ?
    ecpri_pkg::VLAN_MAX : w_vlan;
  wire msg_ok = wdata[7:0] <= ecpri_pkg::MT_MAX;
  wire rma_ok = (wdata[ecpri_pkg::F_RW +: 4] <= ecpri_pkg::RW_MAX) &&
    (wdata[ecpri_pkg::F_RR +: 4] <= ecpri_pkg::RR_MAX);
  wire rst_ok = (wdata[7:0] == ecpri_pkg::RST_REQ) ||
    (wdata[7:0] == ecpri_pkg::RST_RSP);
  wire [15:0] w_rate = wdata[15:0];
  wire [1:0] w_if = wdata[ecpri_pkg::F_IF +: 2];
  wire hi_ok = (w_rate == ecpri_pkg::RATE_25G) &&
    (w_if == ecpri_pkg::IF_SFP28);
  wire lo_ok = (w_rate >= ecpri_pkg::RATE_MIN) &&
    (w_rate <= ecpri_pkg::RATE_MAX) && (w_if != ecpri_pkg::IF_SFP28);
  wire rate_ok = hi_rate_q ? hi_ok : lo_ok;
  wire hi_chg = wr_ctrl && (wdata[ecpri_pkg::C_HI] != hi_rate_q);
  wire opp_ok = !opp_port_active;
  wire bad_wr = (wr_msg && !msg_ok) || (wr_rma && !rma_ok) ||
    (wr_rst && !rst_ok) || (wr_rate && !rate_ok) || (wr_opp && !opp_ok);

  // Sequencer decode.
  wire fec_on = fec_en_q && hi_rate_q;
  wire gen_valid = phase_q != ecpri_pkg::P_IDLE;
  wire adv = ce && gen_valid && gen_s.ready;
  wire [15:0] frame_len = mh_len + paylen_q;
  wire [15:0] tag_len = {12'h000, vlan_depth_q, 2'h0};
  wire [15:0] ph_len =
    (phase_q == ecpri_pkg::P_TAG) ? tag_len :
    (phase_q == ecpri_pkg::P_COM) ? ecpri_pkg::COM_LEN :
    (phase_q == ecpri_pkg::P_MH) ? mh_len :
    (phase_q == ecpri_pkg::P_PAY) ? paylen_q : ecpri_pkg::FEC_LEN;
  wire ph_last = cnt_q == (ph_len - 16'h0001);
  wire gen_last = ph_last && (ph_next == ecpri_pkg::P_IDLE);
  wire frame_end = adv && gen_last;
  wire [30:0] prbs_nx = ecpri_pkg::prbs8(prbs_q);
  wire comp_act = (dly_q[7:0] == ecpri_pkg::ACT_REQ) ||
    (dly_q[7:0] == ecpri_pkg::ACT_RSP) ||
    (dly_q[7:0] == ecpri_pkg::ACT_FUP);
  wire [31:0] comp_eff = comp_act ? comp_q : 32'h0;

  // Correction bytes follow the payload only when enabled at high rate.
  assign ph_next =
    (phase_q == ecpri_pkg::P_TAG) ? ecpri_pkg::P_COM :
    (phase_q == ecpri_pkg::P_COM) ? ecpri_pkg::P_MH :
    (phase_q == ecpri_pkg::P_MH && paylen_q != 16'h0) ? ecpri_pkg::P_PAY :
    (phase_q != ecpri_pkg::P_FEC && fec_on) ? ecpri_pkg::P_FEC :
    ecpri_pkg::P_IDLE;

  wire [7:0] tag_byte =
    (cnt_q[1:0] == 2'h0) ? ecpri_pkg::TPID[15:8] :
    (cnt_q[1:0] == 2'h1) ? ecpri_pkg::TPID[7:0] :
    (cnt_q[1:0] == 2'h2) ? {4'h0, vid_q[11:8]} : vid_q[7:0];
  wire [7:0] com_byte =
    (cnt_q[1:0] == 2'h0) ?
      {ecpri_pkg::REV, ecpri_pkg::RSV, concat_q} :
    (cnt_q[1:0] == 2'h1) ? msg_q :
    (cnt_q[1:0] == 2'h2) ? frame_len[15:8] : frame_len[7:0];
  wire [7:0] fec_byte = cnt_q[0] ? sum_q : par_q;

  assign gen_s.valid = gen_valid;
  assign gen_s.data = {gen_last, gen_byte};

  // Message header layout per type, most significant byte first.
  always_comb begin
    mh_vec = {ids_q, 128'h0};
    mh_len = ecpri_pkg::MH_LEN_ID;
    unique case (msg_q)
      ecpri_pkg::MT_RMA: begin
        // Access id, codes, element, 48-bit address, length.
        mh_vec = {rma_q, 16'h0, mem_addr_q, rma_len_q, 64'h0};
        mh_len = ecpri_pkg::MH_LEN_RMA;
      end
      ecpri_pkg::MT_DLY: begin
        // Measurement id, action, 10-byte stamp, 8-byte compensation.
        mh_vec = {dly_q[15:8], dly_q[7:0], 48'h0, ts_q,
          32'h0, comp_eff};
        mh_len = ecpri_pkg::MH_LEN_DLY;
      end
      ecpri_pkg::MT_RST: begin
        mh_vec = {rst_q, 136'h0};
        mh_len = ecpri_pkg::MH_LEN_RST;
      end
      default: begin
        mh_vec = {ids_q, 128'h0};
        mh_len = ecpri_pkg::MH_LEN_ID;
      end
    endcase
  end

  always_comb begin
    gen_byte = 8'h00;
    unique case (phase_q)
      ecpri_pkg::P_IDLE: gen_byte = 8'h00;
      ecpri_pkg::P_TAG: gen_byte = tag_byte;
      ecpri_pkg::P_COM: gen_byte = com_byte;
      ecpri_pkg::P_MH:
        gen_byte = mh_vec[ecpri_pkg::MH_W - 1 - 8 * int'(cnt_q[4:0]) -: 8];
      ecpri_pkg::P_PAY: gen_byte = prbs_nx[7:0];
      ecpri_pkg::P_FEC: gen_byte = fec_byte;
    endcase
  end

  // Control register; the tag depth never exceeds two.
  always_ff @(posedge clk) begin
    if (srst) begin
      run_q <= 1'b0;
      fec_en_q <= 1'b0;
      hi_rate_q <= 1'b0;
      concat_q <= 1'b0;
      vlan_depth_q <= 2'h0;
    end else if (ce && wr_ctrl) begin
      run_q <= wdata[ecpri_pkg::C_RUN];
      fec_en_q <= wdata[ecpri_pkg::C_FEC];
      hi_rate_q <= wdata[ecpri_pkg::C_HI];
      concat_q <= wdata[ecpri_pkg::C_CAT];
      vlan_depth_q <= vlan_clamp;
    end
  end

  // Header field registers; reserved codes are refused.
  always_ff @(posedge clk) begin
    if (srst) begin
      msg_q <= 8'h00;
      rma_q <= 32'h0;
      rst_q <= {16'h0, ecpri_pkg::RST_REQ};
    end else if (ce) begin
      if (wr_msg && msg_ok) begin
        msg_q <= wdata[7:0];
      end
      if (wr_rma && rma_ok) begin
        rma_q <= wdata;
      end
      if (wr_rst && rst_ok) begin
        rst_q <= wdata[23:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mem_addr_q <= 32'h0;
      rma_len_q <= 16'h0;
      dly_q <= 16'h0;
      ts_q <= 32'h0;
      comp_q <= 32'h0;
      paylen_q <= 16'h0;
      vid_q <= 12'h000;
    end else if (ce) begin
      if (wr_madr) mem_addr_q <= wdata;
      if (wr_mlen) rma_len_q <= wdata[15:0];
      if (wr_dly) dly_q <= wdata[15:0];
      if (wr_ts) ts_q <= wdata;
      if (wr_comp) comp_q <= wdata;
      if (wr_plen) paylen_q <= wdata[15:0];
      if (wr_vid) vid_q <= wdata[11:0];
    end
  end

  // The sequence identifier steps once per frame sent.
  always_ff @(posedge clk) begin
    if (srst) begin
      ids_q <= 32'h0;
      frames_q <= 16'h0;
    end else if (ce) begin
      if (wr_ids) begin
        ids_q <= wdata;
      end else if (frame_end) begin
        ids_q[15:0] <= ids_q[15:0] + 16'h0001;
      end
      if (frame_end) begin
        frames_q <= frames_q + 16'h0001;
      end
    end
  end

  // Port rate and interface; switching the rate option reloads both.
  always_ff @(posedge clk) begin
    if (srst) begin
      port_rate_q <= ecpri_pkg::RATE_MAX;
      iface_q <= ecpri_pkg::IF_SFPP;
    end else if (ce) begin
      if (hi_chg && wdata[ecpri_pkg::C_HI]) begin
        port_rate_q <= ecpri_pkg::RATE_25G;
        iface_q <= ecpri_pkg::IF_SFP28;
      end else if (hi_chg) begin
        port_rate_q <= ecpri_pkg::RATE_MAX;
        iface_q <= ecpri_pkg::IF_SFPP;
      end else if (wr_rate && rate_ok) begin
        port_rate_q <= w_rate;
        iface_q <= w_if;
      end
    end
  end

  // Status flags; a refusal in the clearing cycle still sets the flag.
  always_ff @(posedge clk) begin
    if (srst) begin
      opp_hi_rate_q <= 1'b0;
      reject_q <= 1'b0;
      fec_active_q <= 1'b0;
    end else if (ce) begin
      if (wr_opp && opp_ok) begin
        opp_hi_rate_q <= wdata[0];
      end
      if (bad_wr) begin
        reject_q <= 1'b1;
      end else if (wr_stat && wdata[ecpri_pkg::ST_REJ]) begin
        reject_q <= 1'b0;
      end
      fec_active_q <= fec_on;
    end
  end

  // Frame sequencer.
  always_ff @(posedge clk) begin
    if (srst) begin
      phase_q <= ecpri_pkg::P_IDLE;
      cnt_q <= 16'h0;
      par_q <= 8'h00;
      sum_q <= 8'h00;
    end else if (ce && !gen_valid && run_q) begin
      phase_q <= (vlan_depth_q != 2'h0) ?
        ecpri_pkg::P_TAG : ecpri_pkg::P_COM;
      cnt_q <= 16'h0;
      par_q <= 8'h00;
      sum_q <= 8'h00;
    end else if (adv) begin
      phase_q <= ph_last ? ph_next : phase_q;
      cnt_q <= ph_last ? 16'h0 : cnt_q + 16'h0001;
      par_q <= par_q ^ gen_byte;
      sum_q <= sum_q + gen_byte;
    end
  end

  // The payload sequence is never reseeded between frames.
  always_ff @(posedge clk) begin
    if (srst) begin
      prbs_q <= ecpri_pkg::PRBS_SEED;
    end else if (adv && phase_q == ecpri_pkg::P_PAY) begin
      prbs_q <= prbs_nx;
    end
  end

  // Register read port; data stand only in the cycle after the strobe.
  wire [31:0] ctrl_rd = {26'h0, vlan_depth_q, concat_q, hi_rate_q,
    fec_en_q, run_q};
  wire [31:0] stat_rd = {frames_q, 14'h0, reject_q, gen_valid};
  wire [31:0] rd_mux =
    (addr == ecpri_pkg::A_CTRL) ? ctrl_rd :
    (addr == ecpri_pkg::A_MSG) ? {24'h0, msg_q} :
    (addr == ecpri_pkg::A_IDS) ? ids_q :
    (addr == ecpri_pkg::A_RMA) ? rma_q :
    (addr == ecpri_pkg::A_MADR) ? mem_addr_q :
    (addr == ecpri_pkg::A_MLEN) ? {16'h0, rma_len_q} :
    (addr == ecpri_pkg::A_DLY) ? {16'h0, dly_q} :
    (addr == ecpri_pkg::A_TS) ? ts_q :
    (addr == ecpri_pkg::A_COMP) ? comp_q :
    (addr == ecpri_pkg::A_RST) ? {8'h0, rst_q} :
    (addr == ecpri_pkg::A_PLEN) ? {16'h0, paylen_q} :
    (addr == ecpri_pkg::A_RATE) ? {14'h0, iface_q, port_rate_q} :
    (addr == ecpri_pkg::A_VID) ? {20'h0, vid_q} :
    (addr == ecpri_pkg::A_STAT) ? stat_rd :
    (addr == ecpri_pkg::A_OPP) ? {31'h0, opp_hi_rate_q} : 32'h0;

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 32'h0;
    end else if (ce) begin
      rdata_q <= rd_en ? rd_mux : 32'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  fec_phase_a: assert property (
    gen_valid && gen_last |-> (phase_q == ecpri_pkg::P_FEC) == fec_on)
    else $error("correction bytes disagree with enable");

  hi_rate_a: assert property (
    hi_rate_q |-> port_rate_q == ecpri_pkg::RATE_25G &&
      iface_q == ecpri_pkg::IF_SFP28)
    else $error("high rate option not at 25G on SFP28");

  lo_rate_a: assert property (
    !hi_rate_q |-> port_rate_q >= ecpri_pkg::RATE_MIN &&
      port_rate_q <= ecpri_pkg::RATE_MAX)
    else $error("low rate option out of range");

  opp_hold_a: assert property (
    ce && opp_port_active |=> $stable(opp_hi_rate_q))
    else $error("opposite rate changed while port active");

  vlan_tag_a: assert property (
    phase_q == ecpri_pkg::P_TAG |-> cnt_q < 16'h0008)
    else $error("more than two VLAN tags");

  rev_field_a: assert property (
    phase_q == ecpri_pkg::P_COM && cnt_q == 16'h0 |->
      gen_byte[7:1] == {ecpri_pkg::REV, ecpri_pkg::RSV})
    else $error("revision or reserved bits wrong");

  concat_flag_a: assert property (
    phase_q == ecpri_pkg::P_COM && cnt_q == 16'h0 |->
      gen_byte[0] == concat_q)
    else $error("concatenation flag wrong");

  length_field_a: assert property (
    adv && phase_q == ecpri_pkg::P_COM && cnt_q == 16'h0003 |->
      gen_byte == 8'(mh_len + paylen_q))
    else $error("length field wrong");

  rma_codes_a: assert property (
    rma_q[ecpri_pkg::F_RW +: 4] <= ecpri_pkg::RW_MAX &&
      rma_q[ecpri_pkg::F_RR +: 4] <= ecpri_pkg::RR_MAX)
    else $error("reserved memory access code held");

  comp_zero_a: assert property (
    phase_q == ecpri_pkg::P_MH && msg_q == ecpri_pkg::MT_DLY &&
      !comp_act |-> mh_vec[31:0] == 32'h0)
    else $error("compensation sent for wrong action");

  reset_code_a: assert property (
    rst_q[7:0] == ecpri_pkg::RST_REQ || rst_q[7:0] == ecpri_pkg::RST_RSP)
    else $error("reserved reset code held");

  prbs_step_a: assert property (
    adv && phase_q == ecpri_pkg::P_PAY |=> prbs_q != $past(prbs_q) &&
      prbs_q != 31'h0)
    else $error("payload sequence stalled");
endmodule

// >>> ecpri_pkg.sv
// Constants, register map and helper functions for the test frame builder.
package ecpri_pkg;
  // Register byte addresses.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_MSG = 8'h04;
  localparam logic [7:0] A_IDS = 8'h08;
  localparam logic [7:0] A_RMA = 8'h0c;
  localparam logic [7:0] A_MADR = 8'h10;
  localparam logic [7:0] A_MLEN = 8'h14;
  localparam logic [7:0] A_DLY = 8'h18;
  localparam logic [7:0] A_TS = 8'h1c;
  localparam logic [7:0] A_COMP = 8'h20;
  localparam logic [7:0] A_RST = 8'h24;
  localparam logic [7:0] A_PLEN = 8'h28;
  localparam logic [7:0] A_RATE = 8'h2c;
  localparam logic [7:0] A_VID = 8'h30;
  localparam logic [7:0] A_STAT = 8'h34;
  localparam logic [7:0] A_OPP = 8'h38;
  // Field positions.
  localparam int C_RUN = 0;
  localparam int C_FEC = 1;
  localparam int C_HI = 2;
  localparam int C_CAT = 3;
  localparam int C_VL = 4;
  localparam int F_RW = 20;
  localparam int F_RR = 16;
  localparam int F_IF = 16;
  localparam int F_HI8 = 8;
  localparam int ST_REJ = 1;
  localparam int ST_CNT = 16;
  // Common header content.
  localparam logic [3:0] REV = 4'h1;
  localparam logic [2:0] RSV = 3'h0;
  // Message types.
  localparam logic [7:0] MT_RMA = 8'h04;
  localparam logic [7:0] MT_DLY = 8'h05;
  localparam logic [7:0] MT_RST = 8'h06;
  localparam logic [7:0] MT_MAX = 8'h06;
  // Field codes.
  localparam logic [3:0] RW_MAX = 4'h2;
  localparam logic [3:0] RR_MAX = 4'h2;
  localparam logic [7:0] RST_REQ = 8'h01;
  localparam logic [7:0] RST_RSP = 8'h02;
  localparam logic [7:0] ACT_REQ = 8'h00;
  localparam logic [7:0] ACT_RSP = 8'h02;
  localparam logic [7:0] ACT_FUP = 8'h05;
  // Interface types and rates in Mbit/s.
  localparam logic [1:0] IF_SFPP = 2'h2;
  localparam logic [1:0] IF_SFP28 = 2'h3;
  localparam logic [15:0] RATE_25G = 16'h61a8;
  localparam logic [15:0] RATE_MIN = 16'h000a;
  localparam logic [15:0] RATE_MAX = 16'h2710;
  // Framing sizes.
  localparam logic [1:0] VLAN_MAX = 2'h2;
  localparam logic [15:0] TPID = 16'h8100;
  localparam logic [15:0] COM_LEN = 16'h0004;
  localparam logic [15:0] FEC_LEN = 16'h0002;
  localparam logic [15:0] MH_LEN_ID = 16'h0004;
  localparam logic [15:0] MH_LEN_RMA = 16'h000c;
  localparam logic [15:0] MH_LEN_DLY = 16'h0014;
  localparam logic [15:0] MH_LEN_RST = 16'h0003;
  localparam int MH_W = 160;
  localparam logic [30:0] PRBS_SEED = 31'h7fffffff;
  localparam int PRBS_TA = 30;
  localparam int PRBS_TB = 27;

  typedef enum logic [2:0] {P_IDLE, P_TAG, P_COM, P_MH, P_PAY, P_FEC} phase_e;

  // Advances the 31-stage sequence by eight bits.
  function automatic logic [30:0] prbs8(input logic [30:0] s);
    logic [30:0] r;
    r = s;
    for (int i = 0; i < 8; i++) begin
      r = {r[29:0], r[PRBS_TA] ^ r[PRBS_TB]};
    end
    return r;
  endfunction
endpackage

// >>> frame_sink.sv
// Far-end byte sink that can stall and records every byte it takes.
`timescale 1ns/1ps
module frame_sink (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Byte stream.
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic out_valid,
  output logic out_ready,
  // Stall control: when high, ready drops every other cycle.
  input wire logic stall
);
  logic [8:0] q[$];
  logic tog_q;
  initial out_ready = 1'b0;
  always @(posedge clk) begin
    tog_q <= srst ? 1'b0 : ~tog_q;
    out_ready <= !srst && !(stall && tog_q);
    if (out_valid && out_ready) begin
      q.push_back({out_last, out_data});
    end
  end
endmodule

// >>> tb_ecpri_frame_builder.sv
// Self-checking bench for the test frame builder.
`timescale 1ns/1ps
module tb_ecpri_frame_builder;
  logic clk, srst, ce, wr_en, rd_en, opp_port_active, out_ready, stall;
  logic out_last, out_valid, fec_active_q, opp_hi_rate_q;
  logic [7:0] addr, out_data;
  logic [31:0] wdata, rdata_q, r;
  logic [15:0] port_rate_q;
  logic [1:0] iface_q;
  logic [30:0] ps;
  logic [8:0] exp[$];
  int failures, checked;
  ecpri_frame_builder #(.FIFO_DEPTH(4)) i_dut (.clk(clk), .srst(srst),
    .ce(ce), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata_q(rdata_q), .opp_port_active(opp_port_active),
    .out_data(out_data), .out_last(out_last), .out_valid(out_valid),
    .out_ready(out_ready), .port_rate_q(port_rate_q), .iface_q(iface_q),
    .fec_active_q(fec_active_q), .opp_hi_rate_q(opp_hi_rate_q));
  frame_sink i_sink (.clk(clk), .srst(srst), .out_data(out_data),
    .out_last(out_last), .out_valid(out_valid), .out_ready(out_ready),
    .stall(stall));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task end_sim;
    if (failures == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata_q;
  endtask
  // Appends the next expected payload byte of the running sequence.
  task pb;
    for (int i = 0; i < 8; i++) begin
      ps = {ps[29:0], ps[ecpri_pkg::PRBS_TA] ^ ps[ecpri_pkg::PRBS_TB]};
    end
    exp.push_back({1'b0, ps[7:0]});
  endtask
  // Starts exactly one frame and compares it with the expected bytes.
  task frame(input logic [31:0] ctl);
    int n;
    i_sink.q.delete();
    exp[exp.size()-1][8] = 1'b1;
    wr(ecpri_pkg::A_CTRL, ctl | 32'h1);
    wr(ecpri_pkg::A_CTRL, ctl);
    for (n = 0; n < 500 && i_sink.q.size() < exp.size(); n++) begin
      @(posedge clk);
    end
    if (n >= 500) begin
      failures++;
      end_sim();
    end
    repeat (20) @(posedge clk);
    chk(i_sink.q.size(), exp.size());
    foreach (exp[i]) chk(i_sink.q[i], exp[i]);
  endtask
  task s_rate;
    chk({iface_q, port_rate_q}, {2'h2, 16'h2710});
    wr(ecpri_pkg::A_CTRL, 32'h6);
    // The enable flag follows the control bits one cycle later.
    @(posedge clk);
    #1;
    chk({fec_active_q, iface_q, port_rate_q}, 19'h761a8);
    wr(ecpri_pkg::A_RATE, 32'h32710);
    chk(port_rate_q, 16'h61a8);
    wr(ecpri_pkg::A_CTRL, 32'h2);
    @(posedge clk);
    #1;
    chk({fec_active_q, iface_q, port_rate_q}, 19'h22710);
    wr(ecpri_pkg::A_STAT, 32'h2);
    wr(ecpri_pkg::A_RATE, 32'h10009);
    rd(ecpri_pkg::A_STAT, r);
    chk({r[1], port_rate_q}, 17'h12710);
    wr(ecpri_pkg::A_RATE, 32'h1000a);
    chk({iface_q, port_rate_q}, 18'h1000a);
  endtask
  task s_access;
    wr(ecpri_pkg::A_STAT, 32'h2);
    @(posedge clk) opp_port_active <= 1'b1;
    wr(ecpri_pkg::A_OPP, 32'h1);
    chk(opp_hi_rate_q, 1'b0);
    @(posedge clk) opp_port_active <= 1'b0;
    wr(ecpri_pkg::A_OPP, 32'h1);
    chk(opp_hi_rate_q, 1'b1);
    wr(ecpri_pkg::A_RMA, 32'h7f210abc);
    wr(ecpri_pkg::A_RMA, 32'h01234567);
    rd(ecpri_pkg::A_RMA, r);
    chk(r, 32'h7f210abc);
    rd(8'h3c, r);
    chk(r, 32'h0);
  endtask
  task s_frame_fec;
    logic [7:0] x, s;
    wr(ecpri_pkg::A_VID, 32'h5a3);
    wr(ecpri_pkg::A_MSG, 32'h6);
    wr(ecpri_pkg::A_RST, 32'h00beef02);
    wr(ecpri_pkg::A_PLEN, 32'h4);
    exp = '{9'h81, 9'h00, 9'h05, 9'ha3, 9'h81, 9'h00, 9'h05, 9'ha3,
      9'h11, 9'h06, 9'h00, 9'h07, 9'hbe, 9'hef, 9'h02};
    repeat (4) pb();
    x = 8'h00;
    s = 8'h00;
    foreach (exp[i]) begin
      x ^= exp[i][7:0];
      s += exp[i][7:0];
    end
    exp.push_back({1'b0, x});
    // The sum byte also counts the parity byte sent just before it.
    exp.push_back({1'b1, s + x});
    stall = 1'b1;
    frame(32'h2e);
    stall = 1'b0;
  endtask
  task s_frame_ids;
    wr(ecpri_pkg::A_MSG, 32'h0);
    wr(ecpri_pkg::A_IDS, 32'h12340042);
    exp = '{9'h10, 9'h00, 9'h00, 9'h08, 9'h12, 9'h34, 9'h00, 9'h42};
    repeat (4) pb();
    frame(32'h04);
    rd(ecpri_pkg::A_IDS, r);
    chk(r, 32'h12340043);
  endtask
  // Delay frames without payload, actions 01 and 02: compensation only for action 02.
  task s_frame_dly;
    logic [159:0] h;
    wr(ecpri_pkg::A_MSG, 32'h5);
    wr(ecpri_pkg::A_TS, 32'h11223344);
    wr(ecpri_pkg::A_COMP, 32'haabbccdd);
    wr(ecpri_pkg::A_PLEN, 32'h0);
    for (int k = 1; k < 3; k++) begin
      wr(ecpri_pkg::A_DLY, 32'h3a00 | k);
      h = {8'h3a, 8'(k), 48'h0, 32'h11223344, 32'h0, 32'h0};
      if (k == 2) begin
        h[31:0] = 32'haabbccdd;
      end
      exp = '{9'h10, 9'h05, 9'h00, 9'h14};
      for (int i = 19; i >= 0; i--) exp.push_back({1'b0, h[8*i +: 8]});
      frame(32'h04);
    end
  endtask
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    opp_port_active = 1'b0;
    stall = 1'b0;
    failures = 0;
    checked = 0;
    ps = ecpri_pkg::PRBS_SEED;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    s_rate();
    s_access();
    s_frame_fec();
    s_frame_ids();
    s_frame_dly();
    end_sim();
  end
endmodule
